// file: shared/flash_front_pkg.sv
// constants, opcodes and carriers for the serial flash command front end
// assumes one system clock at CLOCK_MHZ and a host-driven serial clock
package flash_front_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLOCK_MHZ = 10;
  // internal status-write, program and erase cycle; plain default
  localparam int CYCLE_TIME_US = 20;
  localparam int CYCLE_COUNT = CYCLE_TIME_US * CLOCK_MHZ;
  localparam int BUSY_W = 16;

  // ************************************************************
  // frame lengths in serial bits
  // ************************************************************
  localparam int NBITS_W = 12;
  localparam logic [NBITS_W-1:0] STEP_SINGLE = 12'h001;
  localparam logic [NBITS_W-1:0] STEP_QUAD = 12'h004;
  localparam logic [NBITS_W-1:0] OPCODE_BITS = 12'h008;
  localparam logic [NBITS_W-1:0] STATUS_WRITE_BITS = 12'h010;
  localparam logic [NBITS_W-1:0] ERASE_BITS = 12'h020;
  localparam logic [NBITS_W-1:0] WAKE_MIN_BITS = 12'h020;
  localparam logic [NBITS_W-1:0] PAGE_MIN_BITS = 12'h028;

  // ************************************************************
  // opcodes
  // ************************************************************
  localparam logic [7:0] SOFT_RESET_ARM_CMD = 8'h66;
  localparam logic [7:0] SOFT_RESET_CMD = 8'h99;
  localparam logic [7:0] QUAD_MODE_ENTER_CMD = 8'h38;
  localparam logic [7:0] QUAD_MODE_EXIT_CMD = 8'hff;
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] VOLATILE_ENABLE_CMD = 8'h50;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS2_READ_CMD = 8'h09;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] DEEP_SLEEP_CMD = 8'hb9;
  localparam logic [7:0] WAKE_AND_READ_ID_CMD = 8'hab;
  localparam logic [7:0] MAKER_PART_ID_CMD = 8'h90;
  localparam logic [7:0] THREE_BYTE_ID_READ_CMD = 8'h9f;
  localparam logic [7:0] PAGE_WRITE_CMD = 8'h02;
  localparam logic [7:0] QUAD_PAGE_WRITE_CMD = 8'h32;
  localparam logic [7:0] FOUR_KILOBYTE_CLEAR_CMD = 8'h20;
  localparam logic [7:0] HALF_BLOCK_WIPE_CMD = 8'h52;
  localparam logic [7:0] FULL_BLOCK_WIPE_CMD = 8'hd8;

  // ************************************************************
  // identification bytes (values arbitrary)
  // ************************************************************
  localparam logic [7:0] MAKER_CODE = 8'h5a;
  localparam logic [7:0] MEMORY_TYPE_CODE = 8'h40;
  localparam logic [7:0] CAPACITY_CODE = 8'h2c;
  localparam logic [7:0] DEVICE_ID_CODE = 8'h15;

  // ************************************************************
  // status byte fields and reset values
  // ************************************************************
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BOOT_LOCK = 3;
  localparam int ST_TOP_BOTTOM = 5;
  localparam int ST_GRANULARITY = 6;
  localparam int ST2_QUAD = 0;
  localparam int ST2_DEEP_SLEEP = 1;
  localparam int ST2_VOLATILE_ARMED = 2;
  localparam int ST2_RESET_ARMED = 3;
  localparam logic PROTECT_BIT_RESET = 1'b0;

  // ************************************************************
  // address map
  // ************************************************************
  localparam logic [23:0] ARRAY_TOP = 24'h3fffff;
  localparam logic [23:0] PAGE_MASK = 24'h0000ff;
  localparam logic [23:0] SECTOR_MASK = 24'h000fff;
  localparam logic [23:0] HALF_BLOCK_MASK = 24'h007fff;
  localparam logic [23:0] BLOCK_MASK = 24'h00ffff;

  typedef enum logic [2:0] {
    ARR_PAGE, ARR_QUAD_PAGE, ARR_SECTOR, ARR_HALF_BLOCK, ARR_BLOCK
  } array_op_e;

  typedef struct packed {
    array_op_e op;
    logic [23:0] addr;
  } array_req_s;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [NBITS_W-1:0] nbits;
  } frame_s;

endpackage

// file: rtl/serial_flash_command_front_end.sv
// command front end of a serial flash: frame capture on the serial clock,
// command checking and protection state on the system clock.
// assumes chip select stays high at least four system clocks between frames
// and that the serial clock does not toggle while chip select is high.
//
// Overview of operation
// RULE1: program or erase touching the locked boot region is ignored.
// RULE2: granularity bit 0 locks a 64KB block, 1 locks a 4KB sector.
// RULE3: top-or-bottom bit 0 locks the top region, 1 the bottom.
// RULE4: boot lock bit, default 0, enables the lock; one-time or volatile.
// RULE5: bits move msb first, sampled on serial clock rising edges.
// RULE6: host begins each command with one opcode byte.
// RULE7: host ends non-reading commands only after their last bit.
// RULE8: read commands get an output phase the host may cut anywhere; the code drives no output while in quad mode.
// RULE9: write commands run only when the bit count is a multiple of eight.
// RULE10: page write ending in a partial byte does nothing, latch stays set.
// RULE11: page writes and wake-id need their minimum byte count.
// RULE12: page write needs three address bytes and at least one data byte.
// RULE13: erases need exactly a 24-bit address.
// RULE14: array accesses are ignored while an internal cycle runs.
// RULE15: soft reset works only right after the reset-arm command.
// RULE16: quad exit is eight clocks single-line, two clocks in quad mode.
// RULE17: host sends volatile enable directly before the status write.
// RULE18: status reads repeat the status byte until chip select rises.
// RULE19: wake-id takes three dummy bytes, then repeats the device id.
// RULE20: maker/part read alternates ids, fourth byte picks the first.
// RULE21: three-byte id read returns maker, type, capacity.
// RULE22: read data leaves on the data output pin msb first.
// RULE23: unknown opcodes and their trailing clocks are ignored.
`timescale 1ns/10ps
module serial_flash_command_front_end
  import flash_front_pkg::*;
(
  // system side
  input wire logic clock,
  input wire logic rst_n,
  // flash bus pins
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  input wire logic [3:1] quad_data_in,
  output logic data_out,
  output logic data_out_oe_n,
  // device state
  output logic [7:0] status_byte,
  output logic [7:0] status2_byte,
  output logic quad_mode,
  output logic deep_power_down,
  // array back end
  output logic array_req_valid,
  output array_req_s array_req
);

  typedef enum logic [3:0] {
    ACT_NONE, ACT_WREN, ACT_WRDI, ACT_VOL_EN, ACT_ARM, ACT_RESET,
    ACT_QENTER, ACT_QEXIT, ACT_SW, ACT_ARRAY, ACT_SLEEP, ACT_WAKE
  } act_e;

  // ************************************************************
  // link domain: frame capture
  // ************************************************************
  logic start_pending;
  logic [NBITS_W-1:0] cnt;
  logic [NBITS_W-1:0] base;
  logic [NBITS_W-1:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic byte_done;
  logic [8:0] byte_idx;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [7:0] sel_byte;
  logic [15:0] state_meta;
  logic [15:0] state_sync;
  logic quad_link;
  logic [7:0] out_byte;
  logic out_valid;
  logic [8:0] out_idx;
  logic drive;
  frame_s frame;

  // chip select high marks the next edge as the first of a frame
  always_ff @(posedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      start_pending <= 1'b1;
    end else begin
      start_pending <= 1'b0;
    end
  end

  // quad mode settles at least a clock before chip select may fall again,
  // and the serial clock is idle then, so the frame start captures it
  always_ff @(negedge chip_select_n) begin
    quad_link <= quad_mode;
  end

  always_comb begin
    base = start_pending ? '0 : cnt;
    next_cnt = (&base[NBITS_W-1:3]) ? base : base + (quad_link ? STEP_QUAD : STEP_SINGLE);
    next_shreg = quad_link ? {shreg[3:0], quad_data_in, serial_data_in} : {shreg[6:0], serial_data_in}; // RULE5
    byte_done = (next_cnt[2:0] == 3'h0) && (next_cnt != base);
    byte_idx = base[NBITS_W-1:3];
  end

  always_ff @(posedge serial_clock) begin
    cnt <= next_cnt;
    shreg <= next_shreg;
  end

  // the count survives chip select high, so the system side reads it stable
  always_ff @(posedge serial_clock) begin
    if (byte_done) begin
      if (byte_idx == 9'h000) begin
        opcode <= next_shreg; // RULE6
      end else if (byte_idx <= 9'h003) begin
        addr <= {addr[15:0], next_shreg};
      end
      if (byte_idx == 9'h003) begin
        sel_byte <= next_shreg;
      end
    end
  end

  // status changes only between frames, except busy, which may fall mid-frame; first bytes give the sync time
  always_ff @(posedge serial_clock) begin
    state_meta <= {status2_byte, status_byte};
    state_sync <= state_meta;
  end

  // ************************************************************
  // link domain: output phase
  // ************************************************************
  assign out_idx = cnt[NBITS_W-1:3];

  always_comb begin
    out_byte = 8'h00;
    out_valid = 1'b0;
    case (opcode)
      STATUS_READ_CMD: begin
        out_valid = out_idx >= 9'h001; // RULE18
        out_byte = state_sync[7:0];
      end
      STATUS2_READ_CMD: begin
        out_valid = out_idx >= 9'h001; // RULE18
        out_byte = state_sync[15:8];
      end
      WAKE_AND_READ_ID_CMD: begin
        out_valid = out_idx >= 9'h004; // RULE19
        out_byte = DEVICE_ID_CODE;
      end
      MAKER_PART_ID_CMD: begin
        out_valid = out_idx >= 9'h004;
        out_byte = (out_idx[0] ^ sel_byte[0]) ? DEVICE_ID_CODE : MAKER_CODE; // RULE20
      end
      THREE_BYTE_ID_READ_CMD: begin
        out_valid = (out_idx >= 9'h001) && (out_idx <= 9'h003);
        if (out_idx == 9'h001) begin
          out_byte = MAKER_CODE; // RULE21
        end else if (out_idx == 9'h002) begin
          out_byte = MEMORY_TYPE_CODE;
        end else begin
          out_byte = CAPACITY_CODE;
        end
      end
      default: begin
        out_valid = 1'b0; // RULE23
      end
    endcase
  end

  // launch on the falling edge so the host samples on the next rise
  always_ff @(negedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      data_out <= 1'b0;
      drive <= 1'b0;
    end else begin
      data_out <= out_byte[3'h7 - cnt[2:0]]; // RULE22
      drive <= out_valid && !quad_link; // RULE8
    end
  end

  // output released the moment chip select rises, whatever the bit
  assign data_out_oe_n = chip_select_n | ~drive; // RULE8

  assign frame = '{opcode: opcode, addr: addr, nbits: cnt};

  // ************************************************************
  // system domain: frame end detection
  // ************************************************************
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic frame_end;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= chip_select_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  assign frame_end = cs_sync && !cs_prev; // RULE7

  // ************************************************************
  // system domain: protection
  // ************************************************************
  logic sector_granularity_sel;
  logic top_or_bottom_select;
  logic boot_lock_enable;
  logic nv_granularity;
  logic nv_top_bottom;
  logic nv_boot_lock;
  logic write_enable_latch;
  logic volatile_armed;
  logic soft_reset_armed;
  logic busy;
  logic [BUSY_W-1:0] busy_count;
  logic [23:0] lock_mask;
  logic [23:0] lock_lo;
  logic [23:0] lock_hi;
  logic [23:0] target_mask;
  logic [23:0] target_lo;
  logic [23:0] target_hi;
  logic prot_hit;
  logic mult8;
  logic single;
  logic [7:0] sw_data;
  act_e act;

  always_comb begin
    lock_mask = sector_granularity_sel ? SECTOR_MASK : BLOCK_MASK; // RULE2
    lock_lo = top_or_bottom_select ? 24'h000000 : (ARRAY_TOP & ~lock_mask); // RULE3
    lock_hi = top_or_bottom_select ? lock_mask : ARRAY_TOP;
    case (frame.opcode)
      FOUR_KILOBYTE_CLEAR_CMD: target_mask = SECTOR_MASK;
      HALF_BLOCK_WIPE_CMD: target_mask = HALF_BLOCK_MASK;
      FULL_BLOCK_WIPE_CMD: target_mask = BLOCK_MASK;
      default: target_mask = PAGE_MASK;
    endcase
    target_lo = frame.addr & ~target_mask;
    target_hi = frame.addr | target_mask;
    prot_hit = boot_lock_enable && (target_lo <= lock_hi) && (lock_lo <= target_hi); // RULE1 RULE4
  end

  // ************************************************************
  // system domain: command decode
  // ************************************************************
  assign mult8 = frame.nbits[2:0] == 3'h0;
  assign single = frame.nbits == OPCODE_BITS;
  // a 16-bit frame leaves its one data byte in the low address byte
  assign sw_data = frame.addr[7:0];

  always_comb begin
    act = ACT_NONE;
    if (frame_end) begin
      case (frame.opcode)
        WRITE_ENABLE_CMD: act = (single && !deep_power_down) ? ACT_WREN : ACT_NONE;
        WRITE_DISABLE_CMD: act = (single && !deep_power_down) ? ACT_WRDI : ACT_NONE;
        VOLATILE_ENABLE_CMD: act = (single && !deep_power_down) ? ACT_VOL_EN : ACT_NONE;
        SOFT_RESET_ARM_CMD: act = single ? ACT_ARM : ACT_NONE;
        SOFT_RESET_CMD: act = (single && soft_reset_armed) ? ACT_RESET : ACT_NONE; // RULE15
        QUAD_MODE_ENTER_CMD: act = (single && !quad_mode && !deep_power_down) ? ACT_QENTER : ACT_NONE;
        QUAD_MODE_EXIT_CMD: act = single ? ACT_QEXIT : ACT_NONE; // RULE16
        DEEP_SLEEP_CMD: act = (single && !busy) ? ACT_SLEEP : ACT_NONE;
        WAKE_AND_READ_ID_CMD: act = (frame.nbits >= WAKE_MIN_BITS) ? ACT_WAKE : ACT_NONE; // RULE11
        STATUS_WRITE_CMD: begin
          if ((frame.nbits == STATUS_WRITE_BITS) && !busy && !deep_power_down // RULE9 RULE14
              && (write_enable_latch || volatile_armed)) begin // RULE17
            act = ACT_SW;
          end
        end
        PAGE_WRITE_CMD, QUAD_PAGE_WRITE_CMD: begin
          if (mult8 && (frame.nbits >= PAGE_MIN_BITS) && write_enable_latch // RULE9 RULE10 RULE11 RULE12
              && !busy && !deep_power_down && !prot_hit) begin // RULE14 RULE1
            act = ACT_ARRAY;
          end
        end
        FOUR_KILOBYTE_CLEAR_CMD, HALF_BLOCK_WIPE_CMD, FULL_BLOCK_WIPE_CMD: begin
          if ((frame.nbits == ERASE_BITS) && write_enable_latch // RULE13
              && !busy && !deep_power_down && !prot_hit) begin // RULE14 RULE1
            act = ACT_ARRAY;
          end
        end
        default: act = ACT_NONE; // RULE23
      endcase
    end
  end

  // ************************************************************
  // system domain: state
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      soft_reset_armed <= 1'b0;
      volatile_armed <= 1'b0;
    end else if (frame_end) begin
      soft_reset_armed <= act == ACT_ARM; // RULE15
      volatile_armed <= act == ACT_VOL_EN; // RULE17
    end
  end

  // a partial page write leaves act idle, so the latch holds
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
    end else if (act == ACT_WREN) begin
      write_enable_latch <= 1'b1;
    end else if (act == ACT_WRDI || act == ACT_ARRAY || act == ACT_RESET
                 || (act == ACT_SW && !volatile_armed)) begin
      write_enable_latch <= 1'b0; // RULE10
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nv_granularity <= PROTECT_BIT_RESET;
      nv_top_bottom <= PROTECT_BIT_RESET;
      nv_boot_lock <= PROTECT_BIT_RESET;
    end else if (act == ACT_SW && !volatile_armed) begin
      nv_granularity <= sw_data[ST_GRANULARITY];
      nv_top_bottom <= sw_data[ST_TOP_BOTTOM];
      nv_boot_lock <= nv_boot_lock | sw_data[ST_BOOT_LOCK]; // RULE4
    end
  end

  // volatile copy steers protection; soft reset reloads it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sector_granularity_sel <= PROTECT_BIT_RESET;
      top_or_bottom_select <= PROTECT_BIT_RESET;
      boot_lock_enable <= PROTECT_BIT_RESET;
    end else if (act == ACT_RESET) begin
      sector_granularity_sel <= nv_granularity;
      top_or_bottom_select <= nv_top_bottom;
      boot_lock_enable <= nv_boot_lock;
    end else if (act == ACT_SW) begin
      sector_granularity_sel <= sw_data[ST_GRANULARITY]; // RULE2
      top_or_bottom_select <= sw_data[ST_TOP_BOTTOM]; // RULE3
      boot_lock_enable <= volatile_armed ? sw_data[ST_BOOT_LOCK] : (nv_boot_lock | sw_data[ST_BOOT_LOCK]); // RULE4
    end
  end

  // soft reset aborts the cycle; a volatile status write takes no time
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_count <= '0;
      busy <= 1'b0;
    end else if (act == ACT_RESET) begin
      busy_count <= '0;
      busy <= 1'b0;
    end else if (act == ACT_ARRAY || (act == ACT_SW && !volatile_armed)) begin
      busy_count <= BUSY_W'(CYCLE_COUNT);
      busy <= 1'b1;
    end else if (busy_count != '0) begin
      busy_count <= busy_count - 1'b1;
      busy <= busy_count != BUSY_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      quad_mode <= 1'b0;
      deep_power_down <= 1'b0;
    end else begin
      if (act == ACT_QENTER) begin
        quad_mode <= 1'b1;
      end else if (act == ACT_QEXIT || act == ACT_RESET) begin
        quad_mode <= 1'b0; // RULE16
      end
      if (act == ACT_SLEEP) begin
        deep_power_down <= 1'b1;
      end else if (act == ACT_WAKE || act == ACT_RESET) begin
        deep_power_down <= 1'b0; // RULE11
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      array_req_valid <= 1'b0;
      array_req <= '{op: ARR_PAGE, addr: 24'h000000};
    end else begin
      array_req_valid <= act == ACT_ARRAY;
      if (act == ACT_ARRAY) begin
        array_req.addr <= frame.addr;
        case (frame.opcode)
          QUAD_PAGE_WRITE_CMD: array_req.op <= ARR_QUAD_PAGE;
          FOUR_KILOBYTE_CLEAR_CMD: array_req.op <= ARR_SECTOR;
          HALF_BLOCK_WIPE_CMD: array_req.op <= ARR_HALF_BLOCK;
          FULL_BLOCK_WIPE_CMD: array_req.op <= ARR_BLOCK;
          default: array_req.op <= ARR_PAGE;
        endcase
      end
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_BUSY] = busy;
    status_byte[ST_WEL] = write_enable_latch;
    status_byte[ST_BOOT_LOCK] = boot_lock_enable;
    status_byte[ST_TOP_BOTTOM] = top_or_bottom_select;
    status_byte[ST_GRANULARITY] = sector_granularity_sel;
    status2_byte = 8'h00;
    status2_byte[ST2_QUAD] = quad_mode;
    status2_byte[ST2_DEEP_SLEEP] = deep_power_down;
    status2_byte[ST2_VOLATILE_ARMED] = volatile_armed;
    status2_byte[ST2_RESET_ARMED] = soft_reset_armed;
  end

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_partial_page;
    frame_end && frame.opcode == PAGE_WRITE_CMD && frame.nbits[2:0] != 3'h0 && write_enable_latch;
  endsequence

  property p_no_protected_hit;
    @(posedge clock) disable iff (!rst_n) array_req_valid |-> $past(!prot_hit && boot_lock_enable == boot_lock_enable);
  endproperty
  a_no_protected_hit: assert property (p_no_protected_hit) else $error("array request into locked region"); // RULE1

  property p_sector_size;
    @(posedge clock) disable iff (!rst_n) sector_granularity_sel |-> (lock_hi - lock_lo) == SECTOR_MASK;
  endproperty
  a_sector_size: assert property (p_sector_size) else $error("sector lock span wrong"); // RULE2

  property p_top_region;
    @(posedge clock) disable iff (!rst_n) !top_or_bottom_select |-> lock_hi == ARRAY_TOP && lock_lo != 24'h000000;
  endproperty
  a_top_region: assert property (p_top_region) else $error("top lock not at array top"); // RULE3

  property p_lock_off;
    @(posedge clock) disable iff (!rst_n) !boot_lock_enable |-> !prot_hit;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("protection without boot lock"); // RULE4

  property p_byte_boundary;
    @(posedge clock) disable iff (!rst_n) array_req_valid |-> $past(frame.nbits[2:0]) == 3'h0;
  endproperty
  a_byte_boundary: assert property (p_byte_boundary) else $error("write ran off byte boundary"); // RULE9

  property p_partial_page;
    @(posedge clock) disable iff (!rst_n) s_partial_page |=> write_enable_latch && !array_req_valid;
  endproperty
  a_partial_page: assert property (p_partial_page) else $error("partial page write acted"); // RULE10

  property p_page_min;
    @(posedge clock) disable iff (!rst_n)
      array_req_valid && array_req.op inside {ARR_PAGE, ARR_QUAD_PAGE} |-> $past(frame.nbits) >= PAGE_MIN_BITS;
  endproperty
  a_page_min: assert property (p_page_min) else $error("short page write accepted"); // RULE12

  property p_erase_len;
    @(posedge clock) disable iff (!rst_n)
      array_req_valid && array_req.op inside {ARR_SECTOR, ARR_HALF_BLOCK, ARR_BLOCK} |-> $past(frame.nbits) == ERASE_BITS;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase without exact address"); // RULE13

  property p_busy_ignore;
    @(posedge clock) disable iff (!rst_n)
      busy && frame_end && act != ACT_RESET && busy_count > 16'h0001 |=> !array_req_valid && busy;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("array access during busy"); // RULE14

  property p_reset_armed;
    @(posedge clock) disable iff (!rst_n) act == ACT_RESET |-> soft_reset_armed ##1 !quad_mode && !busy;
  endproperty
  a_reset_armed: assert property (p_reset_armed) else $error("soft reset without arm"); // RULE15

  property p_status_stream;
    @(posedge serial_clock) disable iff (chip_select_n)
      !start_pending && !quad_link && opcode == STATUS_READ_CMD && cnt >= 12'h009 |-> drive;
  endproperty
  a_status_stream: assert property (p_status_stream) else $error("status read output stopped"); // RULE18

endmodule

// file: test/flash_host.sv
// host model driving the flash bus pins
// assumes the device launches read bits on serial clock falls
`timescale 1ns/10ps
module flash_host (
  // bus pins
  output logic serial_clock,
  output logic chip_select_n,
  output logic serial_data_in,
  output logic [3:1] quad_data_in,
  input wire logic data_out
);
  initial begin
    serial_clock = 1'b0;
    chip_select_n = 1'b0;
    serial_data_in = 1'b0;
    quad_data_in = 3'h0;
    // a real rising edge clears the link side before the first frame
    #1 chip_select_n = 1'b1;
    #7;
  end
  // ************
  // one frame: nbits sent msb first, then nread bits captured
  // ************
  task automatic xfer(input logic [63:0] tx, input int nbits, input int nread, output logic [63:0] rx);
    rx = 64'h0;
    chip_select_n = 1'b0;
    for (int i = 0; i < nbits + nread; i++) begin
      serial_data_in = tx[63-i];
      // quad lines copy the bit, so an all-ones opcode also works as nibbles
      quad_data_in = {3{tx[63-i]}};
      #16 serial_clock = 1'b1;
      if (i >= nbits) rx = {rx[62:0], data_out};
      #16 serial_clock = 1'b0;
    end
    #16 chip_select_n = 1'b1;
    // released line shows the inverse, not a stale value
    serial_data_in = ~serial_data_in;
    #500;
  endtask
endmodule

// file: test/tb_top.sv
// self-checking bench for the flash command front end
// assumes the host model owns all bus pins
`timescale 1ns/10ps
module tb_top;
  import flash_front_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, csn, mosi, miso, oe_n, arv, qm, dpd;
  logic [3:1] quad;
  logic [7:0] st, st2;
  array_req_s areq;
  logic [63:0] rx;
  int n_errors = 0;
  int n_tests = 0;
  int n_req = 0;
  always #50 clock = ~clock;
  always @(posedge clock) if (arv === 1'b1) n_req++;
  flash_host host (.serial_clock(sclk), .chip_select_n(csn), .serial_data_in(mosi),
    .quad_data_in(quad), .data_out(miso));
  serial_flash_command_front_end dut (.clock(clock), .rst_n(rst_n), .serial_clock(sclk),
    .chip_select_n(csn), .serial_data_in(mosi), .quad_data_in(quad), .data_out(miso),
    .data_out_oe_n(oe_n), .status_byte(st), .status2_byte(st2), .quad_mode(qm),
    .deep_power_down(dpd), .array_req_valid(arv), .array_req(areq));
  // ************
  // checking and closing
  // ************
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmd(input logic [63:0] tx, input int nbits);
    host.xfer(tx, nbits, 0, rx);
  endtask
  initial begin
    #300000;
    n_errors++;
    end_of_test;
  end
  // ************
  // tests
  // ************
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    host.xfer({8'h05, 56'h0}, 8, 16, rx);
    check("status", rx[15:0], 16'h0000);
    host.xfer({8'h9f, 56'h0}, 8, 24, rx);
    check("ident", rx[23:0], {MAKER_CODE, MEMORY_TYPE_CODE, CAPACITY_CODE});
    host.xfer({8'hab, 56'h0}, 32, 16, rx);
    check("dev id", rx[15:0], {DEVICE_ID_CODE, DEVICE_ID_CODE});
    for (int k = 0; k < 2; k++) begin
      host.xfer({8'h90, 16'h0, 7'h0, k[0], 32'h0}, 32, 16, rx);
      check("maker part", rx[15:0], k ? {DEVICE_ID_CODE, MAKER_CODE} : {MAKER_CODE, DEVICE_ID_CODE});
    end
    $display("id reads done");
    cmd({8'h06, 56'h0}, 8);
    check("latch", st[ST_WEL], 1'b1);
    cmd({8'h20, 24'h001000, 32'h0}, 31);
    cmd({8'h20, 24'h001000, 32'h0}, 40);
    cmd({8'h02, 24'h002000, 32'h0}, 32);
    cmd({8'h02, 24'h002000, 32'h0}, 44);
    check("bad frames", n_req, 0);
    check("latch kept", st[ST_WEL], 1'b1);
    cmd({8'h20, 24'h001000, 32'h0}, 32);
    check("erase req", {n_req[0], areq}, {1'b1, ARR_SECTOR, 24'h001000});
    check("busy", st[ST_BUSY], 1'b1);
    $display("erase tests done");
    repeat (250) @(posedge clock);
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h66, 56'h0}, 8);
    cmd({8'h77, 56'h0}, 16);
    cmd({8'h99, 56'h0}, 8);
    check("reset cancelled", st[ST_WEL], 1'b1);
    cmd({8'h66, 56'h0}, 8);
    cmd({8'h99, 56'h0}, 8);
    check("reset done", st[ST_WEL], 1'b0);
    $display("reset tests done");
    cmd({8'h50, 56'h0}, 8);
    check("vol armed", st2[ST2_VOLATILE_ARMED], 1'b1);
    cmd({8'h01, 8'h48, 48'h0}, 16);
    check("vol status", st, 8'h48);
    host.xfer({8'h05, 56'h0}, 8, 8, rx);
    check("status out", rx[7:0], 8'h48);
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h20, 24'h3ff000, 32'h0}, 32);
    check("locked", n_req, 1);
    cmd({8'h20, 24'h3fe000, 32'h0}, 32);
    check("unlocked", n_req, 2);
    $display("protection tests done");
    cmd({8'h38, 56'h0}, 8);
    check("quad on", {qm, st2[ST2_QUAD]}, 2'b11);
    cmd({8'hff, 56'h0}, 2);
    check("quad off", qm, 1'b0);
    repeat (210) @(posedge clock);
    cmd({8'hb9, 56'h0}, 8);
    check("asleep", {dpd, st2[ST2_DEEP_SLEEP]}, 2'b11);
    cmd({8'hab, 56'h0}, 24);
    check("short wake", dpd, 1'b1);
    cmd({8'hab, 56'h0}, 32);
    check("awake", dpd, 1'b0);
    check("released", oe_n, 1'b1);
    $display("power tests done");
    end_of_test;
  end
endmodule
